/* File: hw/watch_pkg.sv */
// Constants, field layout and state types of the basic watchdog timer.
// Assumes one 40 MHz clock that stands for the oscillator clock.
package watch_pkg;

   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam int ADDR_W = 10;
   localparam logic [7:0] CTRL_IDX = 8'hdc;
   localparam logic [7:0] COUNT_IDX = 8'hdd;
   localparam logic [7:0] IRQ_STS_IDX = 8'he0;
   localparam logic [7:0] IRQ_MSK_IDX = 8'he1;
   localparam logic [ADDR_W-1:0] CTRL_ADDR = {CTRL_IDX, 2'b00};
   localparam logic [ADDR_W-1:0] COUNT_ADDR = {COUNT_IDX, 2'b00};
   localparam logic [ADDR_W-1:0] IRQ_STS_ADDR = {IRQ_STS_IDX, 2'b00};
   localparam logic [ADDR_W-1:0] IRQ_MSK_ADDR = {IRQ_MSK_IDX, 2'b00};

   // ---------------------------------------------------------------
   // Control fields
   // ---------------------------------------------------------------
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam int KEY_HI = 7;
   localparam int KEY_LO = 4;
   localparam logic [3:0] WD_OFF_KEY = 4'ha;
   localparam int SEL_HI = 3;
   localparam int SEL_LO = 2;
   localparam int CNT_CLR_BIT = 1;
   localparam int DIV_CLR_BIT = 0;
   localparam logic [1:0] SEL_DIV4096 = 2'h0;
   localparam logic [1:0] SEL_DIV1024 = 2'h1;
   localparam logic [1:0] SEL_DIV128 = 2'h2;

   // ---------------------------------------------------------------
   // Divider and counter
   // ---------------------------------------------------------------
   localparam int DIV_W = 12;
   localparam logic [DIV_W-1:0] MASK_DIV4096 = 12'hfff;
   localparam logic [DIV_W-1:0] MASK_DIV1024 = 12'h3ff;
   localparam logic [DIV_W-1:0] MASK_DIV128 = 12'h07f;
   localparam int CNT_W = 8;
   localparam int CNT_MSB = 7;
   localparam logic [CNT_W-1:0] CNT_MAX = 8'hff;
   localparam logic [CNT_W-1:0] CNT_RESET = 8'h00;

   // ---------------------------------------------------------------
   // Interrupt bits
   // ---------------------------------------------------------------
   localparam int IRQ_W = 2;
   localparam int IRQ_OVF_BIT = 0;
   localparam int IRQ_STAB_BIT = 1;
   localparam int SYNC_W = 3;

   // ---------------------------------------------------------------
   // State types
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_STAB = 3'b001,
      ST_RUN = 3'b010,
      ST_STOP = 3'b100
   } mode_t;

   typedef struct packed {
      logic [DIV_W-1:0] div;
      logic tick;
   } presc_state_t;

   typedef struct packed {
      mode_t mode;
      logic [7:0] ctrl;
      logic [CNT_W-1:0] cnt;
      logic [IRQ_W-1:0] sts;
      logic [IRQ_W-1:0] msk;
      logic [SYNC_W-1:0] sync;
      logic wake_lvl;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic irq;
      logic wd_rst;
      logic cpu_run;
      logic div_clr;
   } core_state_t;

endpackage

/* File: hw/watch_prescaler.sv */
// Oscillator clock divider with a tap multiplexer.
// Assumes clear and run come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module watch_prescaler
   import watch_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clear,
   input wire logic run,
   input wire logic [1:0] sel,
   output logic tick
);

   presc_state_t s_q;
   presc_state_t s_d;
   logic [DIV_W-1:0] mask;

   // ---------------------------------------------------------------
   // Divider
   // ---------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      unique case (sel)
         SEL_DIV1024: mask = MASK_DIV1024;
         SEL_DIV128: mask = MASK_DIV128;
         default: mask = MASK_DIV4096;
      endcase
      s_d.tick = 1'b0;
      if (clear) begin
         s_d.div = '0;
      end else if (run) begin
         s_d.tick = (s_q.div & mask) == mask;
         s_d.div = s_q.div + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign tick = s_q.tick;

endmodule // watch_prescaler
`default_nettype wire

/* File: hw/basic_watchdog_timer.sv */
// Basic watchdog and stabilization timer with APB registers.
// Assumes stop_enter from the CPU on clk; ext_wake is an outside pin.
`timescale 1ns/1ps
`default_nettype none
module basic_watchdog_timer
   import watch_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic stop_enter,
   input wire logic ext_wake,
   output logic watch_reset,
   output logic cpu_run,
   output logic general_div_clear,
   output logic irq
);

   core_state_t s_q;
   core_state_t s_d;
   logic tick;
   logic setup;
   logic access;
   logic wr;
   logic wr_ctrl;
   logic wr_sts;
   logic wr_msk;
   logic mapped;
   logic wake_rise;
   logic wd_enabled;
   logic overflow;
   logic stab_done;
   logic [IRQ_W-1:0] events;
   logic [31:0] rd_val;

   // ---------------------------------------------------------------
   // Prescaler
   // ---------------------------------------------------------------
   watch_prescaler u_presc (
      .clk(clk),
      .rst_n(rst_n),
      .clear(s_q.div_clr),
      .run(s_q.mode != ST_STOP),
      .sel(s_q.ctrl[SEL_HI:SEL_LO]),
      .tick(tick)
   );

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      s_d = s_q;

      // Bus decode
      setup = psel && !penable;
      access = psel && penable && s_q.pready;
      wr = access && pwrite;
      mapped = (paddr == CTRL_ADDR) || (paddr == COUNT_ADDR) ||
               (paddr == IRQ_STS_ADDR) || (paddr == IRQ_MSK_ADDR);
      wr_ctrl = wr && (paddr == CTRL_ADDR);
      wr_sts = wr && (paddr == IRQ_STS_ADDR);
      wr_msk = wr && (paddr == IRQ_MSK_ADDR);

      // Wake pin filter
      s_d.sync = {s_q.sync[SYNC_W-2:0], ext_wake};
      if (s_q.sync[1] == s_q.sync[2]) begin
         s_d.wake_lvl = s_q.sync[2];
      end
      wake_rise = s_d.wake_lvl && !s_q.wake_lvl;

      // Watchdog key
      wd_enabled = s_q.ctrl[KEY_HI:KEY_LO] != WD_OFF_KEY;

      // Counter
      overflow = 1'b0;
      stab_done = 1'b0;
      if (wr_ctrl && pwdata[CNT_CLR_BIT]) begin
         s_d.cnt = CNT_RESET;
      end else if (tick && s_q.mode != ST_STOP) begin
         s_d.cnt = s_q.cnt + 1'b1;
         overflow = s_q.cnt == CNT_MAX;
      end

      // Control register
      if (wr_ctrl) begin
         s_d.ctrl = {pwdata[7:2], 2'b00};
      end
      s_d.div_clr = wr_ctrl && pwdata[DIV_CLR_BIT];

      // Mode sequencing
      s_d.wd_rst = 1'b0;
      unique case (s_q.mode)
         ST_STAB: begin
            s_d.cpu_run = 1'b0;
            if (s_d.cnt[CNT_MSB]) begin
               stab_done = 1'b1;
               s_d.cpu_run = 1'b1;
               s_d.mode = ST_RUN;
            end
         end
         ST_RUN: begin
            if (overflow && wd_enabled) begin
               s_d.wd_rst = 1'b1;
            end
            if (stop_enter) begin
               s_d.mode = ST_STOP;
               s_d.cpu_run = 1'b0;
            end
         end
         ST_STOP: begin
            s_d.cpu_run = 1'b0;
            if (wake_rise) begin
               s_d.cnt = CNT_RESET;
               s_d.mode = ST_STAB;
            end
         end
         default: begin
            s_d.mode = ST_STAB;
            s_d.cpu_run = 1'b0;
         end
      endcase

      // Interrupt status, set wins over clear
      events = '0;
      events[IRQ_OVF_BIT] = overflow;
      events[IRQ_STAB_BIT] = stab_done;
      if (wr_sts) begin
         s_d.sts = s_q.sts & ~pwdata[IRQ_W-1:0];
      end
      s_d.sts = s_d.sts | events;
      if (wr_msk) begin
         s_d.msk = pwdata[IRQ_W-1:0];
      end
      s_d.irq = |(s_d.sts & s_d.msk);

      // Read data
      rd_val = '0;
      if (paddr == CTRL_ADDR) begin
         rd_val[7:0] = s_q.ctrl;
      end else if (paddr == COUNT_ADDR) begin
         rd_val[CNT_W-1:0] = s_q.cnt;
      end else if (paddr == IRQ_STS_ADDR) begin
         rd_val[IRQ_W-1:0] = s_q.sts;
      end else if (paddr == IRQ_MSK_ADDR) begin
         rd_val[IRQ_W-1:0] = s_q.msk;
      end

      // Answer one cycle after setup
      s_d.pready = setup;
      s_d.pslverr = setup && !mapped;
      if (setup) begin
         s_d.prdata = pwrite ? 32'h0000_0000 : rd_val;
      end
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
         s_q.mode <= ST_STAB;
         s_q.ctrl <= CTRL_RESET;
         s_q.cnt <= CNT_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign prdata = s_q.prdata;
   assign pready = s_q.pready;
   assign pslverr = s_q.pslverr;
   assign watch_reset = s_q.wd_rst;
   assign cpu_run = s_q.cpu_run;
   assign general_div_clear = s_q.div_clr;
   assign irq = s_q.irq;

endmodule // basic_watchdog_timer
`default_nettype wire

/* File: verif/watch_props.sv */
// Port assertions of the watchdog timer.
// Assumes one clock; bound into the timer top.
`timescale 1ns/1ps
`default_nettype none
module watch_props
   import watch_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic watch_reset,
   input wire logic cpu_run,
   input wire logic general_div_clear
);
   // ------
   // Helpers
   // ------
   logic off_q;
   logic mapped;
   assign mapped = paddr inside {CTRL_ADDR, COUNT_ADDR, IRQ_STS_ADDR, IRQ_MSK_ADDR};
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         off_q <= 1'h0;
      end else if (psel && penable && pready && pwrite && paddr == CTRL_ADDR) begin
         off_q <= pwdata[KEY_HI:KEY_LO] == WD_OFF_KEY;
      end
   end
   // ------
   // Properties
   // ------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_done;
      psel && penable && pready;
   endsequence
   sequence s_div_wr;
      s_done ##0 (pwrite && paddr == CTRL_ADDR && pwdata[DIV_CLR_BIT]);
   endsequence
   AST_ANSWER: assert property (s_setup |=> pready)
      else $error("setup unanswered");
   AST_ONE: assert property (pready |=> !pready)
      else $error("answer too long");
   AST_ERR: assert property (s_done ##0 !mapped |-> pslverr)
      else $error("no error flag");
   AST_LOW: assert property (s_done ##0 (!pwrite && paddr == CTRL_ADDR) |-> prdata[1:0] == 2'h0)
      else $error("strobe bits read back");
   AST_DIV: assert property (s_div_wr |=> general_div_clear ##1 !general_div_clear)
      else $error("divider clear pulse wrong");
   AST_WR: assert property (watch_reset |=> !watch_reset)
      else $error("reset pulse too long");
   AST_RUN: assert property (watch_reset |-> $past(cpu_run))
      else $error("reset outside run");
   AST_OFF: assert property (off_q && $past(off_q) |-> !watch_reset)
      else $error("reset while disabled");
endmodule // watch_props
`default_nettype wire

/* File: verif/tb_top.sv */
// Self-checking bench of the basic watchdog timer.
// Assumes package, timer and checker compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import watch_pkg::*;
;
   typedef struct {
      logic wr;
      logic [ADDR_W-1:0] a;
      logic [31:0] d;
      logic [31:0] exp;
      logic e;
   } row_t;
   logic clk = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic saw_wr = 1'h0, saw_div = 1'h0, clr_saw = 1'h0, stop_enter = 1'h0, ext_wake = 1'h0;
   logic [31:0] held;
   logic [ADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, watch_reset, cpu_run, general_div_clear, irq, err;
   logic [1:0] sel [3] = '{SEL_DIV4096, SEL_DIV1024, SEL_DIV128};
   int dv [3] = '{4096, 1024, 128};
   int n_fail = 0, tests_run = 0, i, k;
   row_t rows [9] = '{
      '{1'h0, CTRL_ADDR, 32'h0, 32'h0, 1'h0}, '{1'h0, COUNT_ADDR, 32'h0, 32'h0, 1'h0},
      '{1'h1, CTRL_ADDR, 32'ha8, 32'h0, 1'h0}, '{1'h0, CTRL_ADDR, 32'h0, 32'ha8, 1'h0},
      '{1'h1, CTRL_ADDR, 32'hab, 32'h0, 1'h0}, '{1'h0, CTRL_ADDR, 32'h0, 32'ha8, 1'h0},
      '{1'h1, IRQ_MSK_ADDR, 32'h3, 32'h0, 1'h0}, '{1'h0, IRQ_MSK_ADDR, 32'h0, 32'h3, 1'h0},
      '{1'h0, 10'h000, 32'h0, 32'h0, 1'h1}};
   basic_watchdog_timer dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .stop_enter(stop_enter), .ext_wake(ext_wake), .watch_reset(watch_reset), .cpu_run(cpu_run),
      .general_div_clear(general_div_clear), .irq(irq));
   always #12.5 clk = ~clk;
   always @(posedge clk) begin
      if (clr_saw) begin
         saw_wr <= 1'h0;
         saw_div <= 1'h0;
      end else begin
         if (watch_reset === 1'h1) saw_wr <= 1'h1;
         if (general_div_clear === 1'h1) saw_div <= 1'h1;
      end
   end
   // ------
   // Tasks
   // ------
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %s exp %h got %h", what, exp, got);
      end
   endtask
   task automatic results();
      $display("compares %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic await(ref logic s, output int n);
      n = 0;
      while (s !== 1'h1 && n < 40000) begin
         @(posedge clk);
         n++;
      end
      if (n == 40000) begin
         n_fail++;
         results();
      end
   endtask
   task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
      int n;
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'h1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'h1 && n < 50);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      if (n == 50) begin
         n_fail++;
         results();
      end
      @(posedge clk);
   endtask
   // ------
   // Sequence
   // ------
   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'h1;
      @(posedge clk);
      for (i = 0; i < 9; i++) begin
         apb(rows[i].wr, rows[i].a, rows[i].d);
         check("row data", rows[i].exp, rd);
         check("row error", {31'h0, rows[i].e}, {31'h0, err});
      end
      $display("table done");
      for (i = 0; i < 3; i++) begin
         apb(1'h1, CTRL_ADDR, {24'h0, 4'ha, sel[i], 2'h3});
         repeat (dv[i] * 3 / 2) @(posedge clk);
         apb(1'h0, COUNT_ADDR, 32'h0);
         check("rate count", 32'h1, rd);
      end
      apb(1'h1, COUNT_ADDR, 32'hff);
      apb(1'h0, COUNT_ADDR, 32'h0);
      check("count kept", 32'h1, rd);
      apb(1'h1, CTRL_ADDR, 32'haa);
      apb(1'h0, COUNT_ADDR, 32'h0);
      check("count cleared", 32'h0, rd);
      clr_saw <= 1'h1;
      @(posedge clk);
      clr_saw <= 1'h0;
      apb(1'h1, CTRL_ADDR, 32'ha9);
      @(posedge clk);
      check("divider clear", 32'h1, {31'h0, saw_div});
      $display("clear done");
      await(cpu_run, k);
      apb(1'h0, COUNT_ADDR, 32'h0);
      check("count bit7", 32'h80, rd & 32'h80);
      apb(1'h0, IRQ_STS_ADDR, 32'h0);
      check("stab status", 32'h2, rd & 32'h2);
      check("irq set", 32'h1, {31'h0, irq});
      apb(1'h1, IRQ_STS_ADDR, 32'h2);
      check("irq clear", 32'h0, {31'h0, irq});
      clr_saw <= 1'h1;
      @(posedge clk);
      clr_saw <= 1'h0;
      repeat (20000) @(posedge clk);
      check("no reset when off", 32'h0, {31'h0, saw_wr});
      apb(1'h0, IRQ_STS_ADDR, 32'h0);
      check("overflow status", 32'h1, rd & 32'h1);
      apb(1'h1, CTRL_ADDR, 32'h0a);
      await(watch_reset, k);
      check("overflow time", 32'h1, {31'h0, k > 32600 && k < 32800});
      $display("watchdog done");
      stop_enter <= 1'h1;
      @(posedge clk);
      stop_enter <= 1'h0;
      @(posedge clk);
      check("stop cpu off", 32'h0, {31'h0, cpu_run});
      apb(1'h0, COUNT_ADDR, 32'h0);
      held = rd;
      repeat (300) @(posedge clk);
      apb(1'h0, COUNT_ADDR, 32'h0);
      check("stop frozen", held, rd);
      ext_wake <= 1'h1;
      await(cpu_run, k);
      check("wake time", 32'h1, {31'h0, k > 16200 && k < 16500});
      apb(1'h0, COUNT_ADDR, 32'h0);
      check("wake bit7", 32'h80, rd & 32'h80);
      $display("stop done");
      results();
   end
endmodule // tb_top
bind basic_watchdog_timer watch_props props (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .watch_reset(watch_reset), .cpu_run(cpu_run), .general_div_clear(general_div_clear));
`default_nettype wire
